//--- verilog/shutter_power_sequencer.sv
// shutter modes, power states and clock bring-up behind an apb slave
//
// Added by the designer: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "seq_consts.svh"

// Functional notes
// - pipelined slave ignores exposure, uses pin
// - pin high integrates, pin low starts readout
// - triggered holds array reset, one frame
// - triggered master rise starts timed exposure
// - triggered master ignores falling edge
// - rise during exposure or frame overhead dropped
// - triggered slave pin drives integration, readout
// - integration and readout sequential, may overlap
// - rolling keeps reset and read pointers
// - rolling resets storage, then transfers signal
// - six power states, host moves them
// - low power standby: clocks off, few registers
// - standby one: clock source on, logic off
// - standby two: logic clock, all registers
// - idle: all but sequencer; enable runs
// - parallel variant bypasses pll, reference clock
// - pll starts after config, lock flag
// - global modes: frame overhead first, row overhead per row
// - sequencer enable bit starts acquisition
// - disabling sequencer returns to idle
module shutter_power_sequencer #(
  parameter int LOCK_CYCLES = `LOCK_CYCLES  // pll settle time in clocks
) (
  input  wire logic        CORE_CLK,        // core clock, 100 MHz
  input  wire logic        RST_B,           // async reset, active low
  input  wire logic        SYNC_PIN,        // external trigger pin
  input  wire logic        PSEL,            // apb select
  input  wire logic        PENABLE,         // apb access phase
  input  wire logic        PWRITE,          // apb direction
  input  wire logic [7:0]  PADDR,           // apb byte address
  input  wire logic [31:0] PWDATA,          // apb write data
  output logic             PREADY,          // apb ready
  output logic [31:0]      PRDATA,          // apb read data
  output logic             PSLVERR,         // apb error
  output logic [2:0]       PWR_STATE,       // operating state
  output logic             PLL_RUN,         // pll enabled
  output logic             CLK_RX_RUN,      // serial clock receiver on
  output logic             PLL_BYPASS,      // logic clocked without pll
  output logic             LOGIC_CLK_ON,    // derived logic clock on
  output logic             BLOCKS_ON,       // functional blocks on
  output logic             PIXEL_RESET,     // whole array held in reset
  output logic             INTEGRATING,     // global integration active
  output logic             FRAME_OVERHEAD,  // frame overhead period
  output logic             ROW_OVERHEAD,    // row overhead period
  output logic             ROW_READ,        // row being read
  output logic [10:0]      READ_ROW,        // read pointer
  output logic [10:0]      RESET_ROW,       // rolling reset pointer
  output logic             STORE_RESET,     // storage node reset pulse
  output logic             SIGNAL_XFER      // signal transfer pulse
);

  // ****************************************
  // helpers and defaults for assertions
  // ****************************************
  localparam logic [15:0] LOCK_LAST = 16'(LOCK_CYCLES - 1);  // last count

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_B);

  // count reaches a length of at least one cycle
  function automatic logic done_at(input logic [15:0] cnt,
                                   input logic [15:0] len);
    done_at = ({1'b0, cnt} + 17'h00001) >= {1'b0, len};
  endfunction

  // ****************************************
  // registers and state
  // ****************************************
  logic [`CM_WIDTH-1:0] clk_mgmt;   // clock management bits
  logic                 blocks_en;  // functional blocks enable
  logic [`SC_WIDTH-1:0] seq_ctrl;   // sequencer enable and mode
  logic [15:0]          exposure;   // cycles (global) or rows (rolling)
  logic [31:0]          timing;     // overhead and row read lengths
  logic [10:0]          rows;       // rows per frame
  logic [15:0]          lock_cnt;   // lock detector counter
  logic                 locked;     // lock flag
  logic [15:0]          exp_cnt;    // exposure counter
  logic [15:0]          rd_cnt;     // readout phase counter
  logic [10:0]          rd_row;     // row being read
  seq_pkg::integ_e      int_st;     // integration state
  seq_pkg::integ_e      next_int;   // its next value
  seq_pkg::read_e       rd_st;      // readout state
  seq_pkg::read_e       next_rd;    // its next value
  seq_pkg::power_e      next_pwr;   // next operating state
  seq_pkg::shutter_e    shutter;    // decoded shutter mode
  logic [31:0]          rd_mux;     // read data select
  logic                 sync_lvl;   // synchronised pin level
  logic                 sync_rise;  // pin rising pulse
  logic                 sync_fall;  // pin falling pulse

  // ****************************************
  // trigger pin synchroniser
  // ****************************************
  pin_sync u_sync (
    .clk   (CORE_CLK),
    .rst_b (RST_B),
    .pin   (SYNC_PIN),
    .level (sync_lvl),
    .rise  (sync_rise),
    .fall  (sync_fall)
  );

  // ****************************************
  // clock and power decode
  // ****************************************
  wire pll_use  = clk_mgmt[`CM_PLL_USE];   // pll chosen
  wire par_out  = clk_mgmt[`CM_PAR_OUT];   // parallel variant
  wire clk_run  = clk_mgmt[`CM_CLK_RUN];   // clock source enabled
  // parallel variant never runs the pll
  wire pll_active = clk_run & pll_use & ~par_out;
  wire rx_active  = clk_run & ~pll_use & ~par_out;
  wire clk_ok     = ~pll_active | locked;
  // logic clock needs generator released and a good source
  wire logic_on = clk_run & clk_mgmt[`CM_GEN_REL]
                & clk_mgmt[`CM_LOGIC_CLK] & clk_ok;
  wire blocks_on = logic_on & blocks_en;
  wire seq_run   = blocks_on & seq_ctrl[`SC_ENABLE];

  // state follows what the host has written and, with the pll in use, the lock flag
  assign next_pwr = !clk_run                ? seq_pkg::PWR_LP_STBY :
                    !logic_on               ? seq_pkg::PWR_STBY1 :
                    !blocks_en              ? seq_pkg::PWR_STBY2 :
                    !seq_ctrl[`SC_ENABLE]   ? seq_pkg::PWR_IDLE :
                                              seq_pkg::PWR_RUN;

  // lock detector, cleared whenever the pll is off
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      lock_cnt <= 16'h0000;
      locked   <= 1'b0;
    end else if (!pll_active) begin
      lock_cnt <= 16'h0000;
      locked   <= 1'b0;
    end else if (lock_cnt == LOCK_LAST) begin
      locked   <= 1'b1;
    end else begin
      lock_cnt <= lock_cnt + 16'h0001;
    end
  end

  a_lock_flag: assert property (
    (pll_active && lock_cnt == LOCK_LAST) ##1 pll_active |-> locked)
    else $error("lock flag not set after settle count");

  a_power_run: assert property (
    seq_run |=> PWR_STATE == seq_pkg::PWR_RUN && BLOCKS_ON)
    else $error("running state not shown");

  // ****************************************
  // apb slave
  // ****************************************
  wire setup   = PSEL & ~PENABLE;                        // setup phase
  wire wr_go   = PSEL & PENABLE & PREADY & PWRITE;       // write edge
  wire mapped  = PADDR[7:5] == 3'h0 && PADDR[1:0] == 2'h0;
  wire cm_regs = PADDR == `OFF_CLK_MGMT || PADDR == `OFF_STATUS;
  // without logic clock only clock management and status stay reachable
  wire reach   = mapped & (logic_on | cm_regs);
  wire wr_ok   = wr_go & reach;

  // read data select
  always_comb begin
    case (PADDR)
      `OFF_CLK_MGMT:  rd_mux = {27'h0, clk_mgmt};
      `OFF_BLOCK_EN:  rd_mux = {31'h0, blocks_en};
      `OFF_SEQ_CTRL:  rd_mux = {28'h0, seq_ctrl};
      `OFF_EXPOSURE:  rd_mux = {16'h0, exposure};
      `OFF_TIMING:    rd_mux = timing;
      `OFF_ROW_COUNT: rd_mux = {21'h0, rows};
      `OFF_STATUS:    rd_mux = {24'h0, rd_st, int_st, locked, PWR_STATE};
      `OFF_ROW_PTRS:  rd_mux = {5'h0, RESET_ROW, 5'h0, READ_ROW};
      default:        rd_mux = 32'h0;
    endcase
  end

  // one wait-free answer per transfer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0;
      PSLVERR <= 1'b0;
    end else begin
      PREADY  <= setup;
      PRDATA  <= (setup & reach & ~PWRITE) ? rd_mux : 32'h0;
      PSLVERR <= setup & ~reach;
    end
  end

  // register writes; contents kept in every state
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clk_mgmt  <= '0;
      blocks_en <= 1'b0;
      seq_ctrl  <= '0;
      exposure  <= `RST_EXPOSURE;
      timing    <= `RST_TIMING;
      rows      <= `RST_ROWS;
    end else if (wr_ok) begin
      case (PADDR)
        `OFF_CLK_MGMT:  clk_mgmt  <= PWDATA[`CM_WIDTH-1:0];
        `OFF_BLOCK_EN:  blocks_en <= PWDATA[0];
        `OFF_SEQ_CTRL:  seq_ctrl  <= PWDATA[`SC_WIDTH-1:0];
        `OFF_EXPOSURE:  exposure  <= PWDATA[15:0];
        `OFF_TIMING:    timing    <= PWDATA;
        `OFF_ROW_COUNT: rows      <= PWDATA[10:0];
        default:        rows      <= rows;
      endcase
    end
  end

  a_lp_write: assert property (
    (wr_go && PADDR == `OFF_EXPOSURE && !logic_on) |=> $stable(exposure))
    else $error("register written without logic clock");

  // ****************************************
  // integration engine (global modes)
  // ****************************************
  assign shutter = seq_pkg::shutter_e'(seq_ctrl[`SC_MODE_HI:`SC_MODE_LO]);
  wire rolling  = shutter == seq_pkg::SH_ROLLING;
  wire trig     = shutter == seq_pkg::SH_TRIGGERED;
  wire slave    = seq_ctrl[`SC_SLAVE];
  wire gs_run   = seq_run & ~rolling;
  wire roll_run = seq_run & rolling;
  wire rd_idle  = rd_st == seq_pkg::RD_IDLE;
  wire in_fot   = rd_st == seq_pkg::RD_FRAME_OH;
  wire exp_done = done_at(exp_cnt, exposure);
  // start: pin in slave, trigger edge outside overhead, or free run
  wire int_go = gs_run & (int_st == seq_pkg::INT_IDLE)
              & (slave ? sync_rise
                       : (~in_fot & (~trig | sync_rise)));
  // end: pin falls in slave, timer in master
  wire int_end = (int_st == seq_pkg::INT_RUN)
               & (slave ? sync_fall : exp_done);
  // a finished exposure waits for a free readout
  wire frame_go = gs_run & rd_idle
                & (int_end | int_st == seq_pkg::INT_HOLD);

  // next integration state
  always_comb begin
    case (int_st)
      seq_pkg::INT_IDLE:
        next_int = int_go ? seq_pkg::INT_RUN : seq_pkg::INT_IDLE;
      seq_pkg::INT_RUN:
        next_int = !int_end ? seq_pkg::INT_RUN :
                   rd_idle  ? seq_pkg::INT_IDLE : seq_pkg::INT_HOLD;
      seq_pkg::INT_HOLD:
        next_int = rd_idle ? seq_pkg::INT_IDLE : seq_pkg::INT_HOLD;
      default:
        next_int = seq_pkg::INT_IDLE;
    endcase
    if (!gs_run) begin
      next_int = seq_pkg::INT_IDLE;
    end
  end

  // integration state and exposure timer
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      int_st  <= seq_pkg::INT_IDLE;
      exp_cnt <= 16'h0000;
    end else begin
      int_st  <= next_int;
      exp_cnt <= int_go ? 16'h0000 : exp_cnt + 16'h0001;
    end
  end

  a_slave_hold: assert property (
    (gs_run && slave && int_st == seq_pkg::INT_RUN && !sync_fall)
      |=> int_st == seq_pkg::INT_RUN)
    else $error("slave exposure ended without pin fall");

  a_rise_start: assert property (
    (gs_run && slave && int_st == seq_pkg::INT_IDLE && sync_rise)
      |=> int_st == seq_pkg::INT_RUN && INTEGRATING && !PIXEL_RESET)
    else $error("pin rise did not start integration");

  a_fall_read: assert property (
    (gs_run && slave && int_st == seq_pkg::INT_RUN && sync_fall && rd_idle)
      |=> FRAME_OVERHEAD && !INTEGRATING)
    else $error("pin fall did not start readout");

  a_trig_drop: assert property (
    (gs_run && trig && !slave && sync_rise
      && (int_st != seq_pkg::INT_IDLE || in_fot))
      |=> !(int_st == seq_pkg::INT_RUN && exp_cnt == 16'h0000))
    else $error("early trigger edge restarted a frame");

  a_fall_ignored: assert property (
    (gs_run && trig && !slave && int_st == seq_pkg::INT_RUN
      && sync_fall && !exp_done) |=> int_st == seq_pkg::INT_RUN)
    else $error("falling edge cut master exposure");

  a_trig_reset: assert property (
    (gs_run && trig && int_st == seq_pkg::INT_IDLE && !int_go)
      |=> PIXEL_RESET && !INTEGRATING)
    else $error("array left reset without request");

  // ****************************************
  // readout engine
  // ****************************************
  wire [15:0] fot_len = timing[`TM_FRAME_OH];
  wire [15:0] rot_raw = {8'h00, timing[`TM_ROW_OH]};
  // rolling needs two overhead cycles for reset then transfer
  wire [15:0] rot_len = (rolling && rot_raw < `ROT_MIN_ROLL) ? `ROT_MIN_ROLL
                                                            : rot_raw;
  wire [15:0] row_len  = {8'h00, timing[`TM_ROW_READ]};
  wire        last_row = rd_row == rows - 11'h001;
  wire        row_step = rd_st == seq_pkg::RD_ROW && done_at(rd_cnt, row_len);

  // next readout state
  always_comb begin
    case (rd_st)
      seq_pkg::RD_IDLE:
        next_rd = frame_go ? seq_pkg::RD_FRAME_OH :
                  roll_run ? seq_pkg::RD_ROW_OH : seq_pkg::RD_IDLE;
      seq_pkg::RD_FRAME_OH:
        next_rd = done_at(rd_cnt, fot_len) ? seq_pkg::RD_ROW_OH
                                           : seq_pkg::RD_FRAME_OH;
      seq_pkg::RD_ROW_OH:
        next_rd = done_at(rd_cnt, rot_len) ? seq_pkg::RD_ROW
                                           : seq_pkg::RD_ROW_OH;
      seq_pkg::RD_ROW:
        next_rd = !row_step              ? seq_pkg::RD_ROW :
                  (last_row && !rolling) ? seq_pkg::RD_IDLE
                                         : seq_pkg::RD_ROW_OH;
      default:
        next_rd = seq_pkg::RD_IDLE;
    endcase
    if (!seq_run) begin
      next_rd = seq_pkg::RD_IDLE;
    end
  end

  wire [15:0] next_cnt = (next_rd != rd_st) ? 16'h0000 : rd_cnt + 16'h0001;
  wire [10:0] next_row = row_step ? (last_row ? 11'h000 : rd_row + 11'h001)
                                  : (rd_idle ? 11'h000 : rd_row);
  // reset pointer leads the read pointer by the exposure in rows
  wire [11:0] ptr_sum  = {1'b0, next_row} + {1'b0, exposure[10:0]};
  wire [10:0] ptr_wrap = (ptr_sum >= {1'b0, rows}) ? 11'(ptr_sum - {1'b0, rows})
                                                   : ptr_sum[10:0];
  wire oh_rolling = roll_run && next_rd == seq_pkg::RD_ROW_OH;

  // readout state and counters
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rd_st  <= seq_pkg::RD_IDLE;
      rd_cnt <= 16'h0000;
      rd_row <= 11'h000;
    end else begin
      rd_st  <= next_rd;
      rd_cnt <= next_cnt;
      rd_row <= next_row;
    end
  end

  sequence s_store_reset;
    STORE_RESET && roll_run;
  endsequence

  sequence s_signal_xfer;
    SIGNAL_XFER && ROW_OVERHEAD && !STORE_RESET;
  endsequence

  a_cds_order: assert property (s_store_reset |=> s_signal_xfer)
    else $error("signal transfer did not follow storage reset");

  a_seq_stop: assert property (
    !seq_run |=> rd_idle && int_st == seq_pkg::INT_IDLE && !ROW_READ)
    else $error("acquisition continued with sequencer off");

  // ****************************************
  // registered outputs
  // ****************************************
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      PWR_STATE      <= 3'(seq_pkg::PWR_LP_STBY);
      PLL_RUN        <= 1'b0;
      CLK_RX_RUN     <= 1'b0;
      PLL_BYPASS     <= 1'b1;
      LOGIC_CLK_ON   <= 1'b0;
      BLOCKS_ON      <= 1'b0;
      PIXEL_RESET    <= 1'b1;
      INTEGRATING    <= 1'b0;
      FRAME_OVERHEAD <= 1'b0;
      ROW_OVERHEAD   <= 1'b0;
      ROW_READ       <= 1'b0;
      READ_ROW       <= 11'h000;
      RESET_ROW      <= 11'h000;
      STORE_RESET    <= 1'b0;
      SIGNAL_XFER    <= 1'b0;
    end else begin
      PWR_STATE      <= next_pwr;
      PLL_RUN        <= pll_active;
      CLK_RX_RUN     <= rx_active;
      PLL_BYPASS     <= par_out | ~pll_use;
      LOGIC_CLK_ON   <= logic_on;
      BLOCKS_ON      <= blocks_on;
      PIXEL_RESET    <= next_int != seq_pkg::INT_RUN && !roll_run;
      INTEGRATING    <= next_int == seq_pkg::INT_RUN;
      FRAME_OVERHEAD <= next_rd == seq_pkg::RD_FRAME_OH;
      ROW_OVERHEAD   <= next_rd == seq_pkg::RD_ROW_OH;
      ROW_READ       <= next_rd == seq_pkg::RD_ROW;
      READ_ROW       <= next_row;
      RESET_ROW      <= roll_run ? ptr_wrap : 11'h000;
      STORE_RESET    <= oh_rolling && next_cnt == 16'h0000;
      SIGNAL_XFER    <= oh_rolling && next_cnt == 16'h0001;
    end
  end

endmodule // shutter_power_sequencer

//--- verilog/seq_consts.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef SEQ_CONSTS_SVH
`define SEQ_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define OFF_CLK_MGMT   8'h00
`define OFF_BLOCK_EN   8'h04
`define OFF_SEQ_CTRL   8'h08
`define OFF_EXPOSURE   8'h0c
`define OFF_TIMING     8'h10
`define OFF_ROW_COUNT  8'h14
`define OFF_STATUS     8'h18
`define OFF_ROW_PTRS   8'h1c

// ****************************************
// clock management fields
// ****************************************
`define CM_PLL_USE     0
`define CM_PAR_OUT     1
`define CM_CLK_RUN     2
`define CM_GEN_REL     3
`define CM_LOGIC_CLK   4
`define CM_WIDTH       5

// ****************************************
// sequencer control fields
// ****************************************
`define SC_ENABLE      0
`define SC_MODE_LO     1
`define SC_MODE_HI     2
`define SC_SLAVE       3
`define SC_WIDTH       4

// ****************************************
// timing word fields
// ****************************************
`define TM_FRAME_OH    15:0
`define TM_ROW_OH      23:16
`define TM_ROW_READ    31:24

// ****************************************
// reset values and counts
// ****************************************
`define RST_EXPOSURE   16'h0100
`define RST_TIMING     32'h08040010
`define RST_ROWS       11'h400
`define ROT_MIN_ROLL   16'h0002
`define LOCK_CYCLES    1000

`endif

//--- verilog/seq_pkg.sv
// state and mode types of the shutter and power sequencer
package seq_pkg;
  // operating states, lowest power first
  typedef enum logic [2:0] {PWR_OFF, PWR_LP_STBY, PWR_STBY1, PWR_STBY2,
                            PWR_IDLE, PWR_RUN} power_e;
  // shutter mode field
  typedef enum logic [1:0] {SH_PIPELINED, SH_TRIGGERED, SH_ROLLING} shutter_e;
  // integration engine
  typedef enum logic [1:0] {INT_IDLE, INT_RUN, INT_HOLD} integ_e;
  // readout engine
  typedef enum logic [1:0] {RD_IDLE, RD_FRAME_OH, RD_ROW_OH, RD_ROW} read_e;
endpackage

//--- verilog/pin_sync.sv
// three-stage synchroniser with edge detection for the trigger pin
`timescale 1ns/100ps

module pin_sync (
  input  wire logic clk,     // core clock
  input  wire logic rst_b,   // async reset, active low
  input  wire logic pin,     // raw pin level
  output logic      level,   // filtered level
  output logic      rise,    // one-cycle pulse on a rising change
  output logic      fall     // one-cycle pulse on a falling change
);

  // ****************************************
  // synchroniser chain
  // ****************************************
  logic s1;  // first stage, read only by s2
  logic s2;  // second stage
  logic s3;  // third stage

  // settled when the last two stages agree
  wire settled = s2 == s3;

  // chain and edge flags
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      s1    <= pin;
      s2    <= s1;
      s3    <= s2;
      level <= settled ? s3 : level;
      rise  <= settled & s3 & ~level;
      fall  <= settled & ~s3 & level;
    end
  end

endmodule // pin_sync

//--- tb/trig_host.sv
// host model that drives the trigger pin of the sequencer
`timescale 1ns/100ps

module trig_host (
  input  wire logic clk,  // core clock
  output logic      pin   // trigger level
);
  // the pin rests low, as a released host output would
  initial pin = 1'b0;

  // high for hi cycles, then low for lo cycles; the next rise may land in a readout
  task automatic pulse(input int hi, input int lo);
    pin <= 1'b1;
    repeat (hi) @(posedge clk);
    pin <= 1'b0;
    repeat (lo) @(posedge clk);
  endtask
endmodule // trig_host

//--- tb/tb_shutter_power_sequencer.sv
// self-checking bench: power bring-up and frames in the triggered, pipelined and rolling modes
`timescale 1ns/100ps

module tb_shutter_power_sequencer;
  logic        clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0; // bus and reset drive
  logic [7:0]  pa = 0;                                        // bus address
  logic [31:0] pwd = 0, prd, r = 0;                           // bus data, last read
  logic        prdy, err, e, pin, pll, integ, fo, prst, fo_d = 0; // observed lines
  logic [2:0]  st;                                            // operating state
  logic        sr, sx, byp, lg, sr_d = 0;                     // rolling pulses, clock lines
  int          bad_count = 0, samples_checked = 0, frames = 0, icnt = 0;
  int          srs = 0, xbad = 0, f0, i0, s0;                 // pulse counts and baselines

  always #5 clk = ~clk;

  trig_host h (.clk(clk), .pin(pin));

  shutter_power_sequencer #(.LOCK_CYCLES(4)) dut (
    .CORE_CLK(clk), .RST_B(rst_b), .SYNC_PIN(pin), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PREADY(prdy), .PRDATA(prd),
    .PSLVERR(err), .PWR_STATE(st), .PLL_RUN(pll), .CLK_RX_RUN(), .PLL_BYPASS(byp),
    .LOGIC_CLK_ON(lg), .BLOCKS_ON(), .PIXEL_RESET(prst), .INTEGRATING(integ),
    .FRAME_OVERHEAD(fo), .ROW_OVERHEAD(), .ROW_READ(), .READ_ROW(), .RESET_ROW(),
    .STORE_RESET(sr), .SIGNAL_XFER(sx));

  // counts frames started and cycles spent integrating
  always @(posedge clk) begin
    fo_d <= fo;
    if (fo && !fo_d) frames <= frames + 1;
    if (integ) icnt <= icnt + 1;
    sr_d <= sr;
    if (sr) srs <= srs + 1;
    if (sx && !sr_d) xbad <= xbad + 1;
  end

  // one bus transfer: setup, then access held until ready
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; pen <= 0; pwr <= w; pa <= a; pwd <= d;
    @(posedge clk) pen <= 1;
    do @(posedge clk); while (prdy !== 1'b1);
    r = prd;
    e = err;
    psel <= 0;
    pen <= 0;
    @(posedge clk);
  endtask

  // compare and count
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      $display("ERROR %s expected %h seen %h", n, x, g);
      bad_count++;
    end
  endtask

  task report_and_stop;
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1;
    repeat (1000) @(posedge clk);
    apb(0, 8'h18, 0);
    chk("status", 32'h1, r);
    apb(1, 8'h0c, 5);
    chk("blocked", 1, e);
    apb(1, 8'h00, 32'h5);
    repeat (2) @(posedge clk);
    chk("stby1", 2, st);
    chk("pll", 1, pll);
    r = 0;
    repeat (20) if (r[3] !== 1'b1) apb(0, 8'h18, 0);
    chk("locked", 32'ha, r);
    apb(1, 8'h00, 32'hd);
    apb(1, 8'h00, 32'h1d);
    repeat (2) @(posedge clk);
    chk("stby2", 3, st);
    apb(1, 8'h0c, 32'h14);
    chk("reachable", 0, e);
    apb(1, 8'h10, 32'h01010002);
    apb(1, 8'h14, 2);
    apb(1, 8'h04, 1);
    repeat (2) @(posedge clk);
    chk("idle", 4, st);
    // triggered master: early rise dropped, falling edges ignored
    apb(1, 8'h08, 3);
    repeat (2) @(posedge clk);
    chk("run", 5, st);
    chk("array", 1, prst);
    h.pulse(3, 3);
    h.pulse(3, 100);
    chk("frames", 1, frames);
    chk("exposure", 20, icnt);
    h.pulse(3, 100);
    chk("frames", 2, frames);
    chk("array", 1, prst);
    // triggered slave: pin level sets exposure, each rise one frame
    f0 = frames;
    i0 = icnt;
    apb(1, 8'h08, 32'hb);
    h.pulse(10, 50);
    h.pulse(10, 50);
    chk("slave frames", f0 + 2, frames);
    chk("slave exposure", i0 + 20, icnt);
    // pipelined slave: exposure register ignored
    f0 = frames;
    i0 = icnt;
    apb(1, 8'h08, 32'h9);
    h.pulse(10, 50);
    chk("pipe frames", f0 + 1, frames);
    chk("pipe exposure", i0 + 10, icnt);
    // pipelined master: frames start with no pin activity
    f0 = frames;
    apb(1, 8'h08, 32'h1);
    repeat (60) @(posedge clk);
    chk("free frames", f0 + 2, frames);
    apb(1, 8'h08, 0);
    repeat (2) @(posedge clk);
    chk("stop", 4, st);
    // rolling: reset row leads read row by one, storage reset first
    apb(1, 8'h0c, 1);
    s0 = srs;
    apb(1, 8'h08, 32'h5);
    repeat (60) @(posedge clk);
    chk("store resets", s0 + 20, srs);
    chk("store order", 0, xbad);
    chk("rolling array", 0, prst);
    apb(0, 8'h1c, 0);
    chk("pointer gap", r[10:0] ^ 11'h001, r[26:16]);
    apb(1, 8'h08, 0);
    repeat (2) @(posedge clk);
    chk("stop", 4, st);
    // second reset, then parallel variant with no lock poll
    rst_b <= 0;
    repeat (10) @(posedge clk);
    rst_b <= 1;
    repeat (1000) @(posedge clk);
    apb(0, 8'h18, 0);
    chk("status", 32'h1, r);
    apb(1, 8'h00, 32'h6);
    apb(1, 8'h00, 32'he);
    apb(1, 8'h00, 32'h1e);
    repeat (2) @(posedge clk);
    chk("bypass", 1, byp);
    chk("pll off", 0, pll);
    chk("logic clock", 1, lg);
    chk("stby2", 3, st);
    apb(0, 8'h0c, 0);
    chk("exposure", 32'h100, r);
    report_and_stop;
  end

  // cuts a hang short
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop;
  end
endmodule // tb_shutter_power_sequencer
